/* File: rtl/audio_fault_pkg.sv */
package audio_fault_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned BCLK_STALL_NS = 10_000;
	localparam int unsigned BCLK_STALL_CYC = (BCLK_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FRAME_STALL_NS = 1_000_000;
	localparam int unsigned FRAME_STALL_CYC =
		(FRAME_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned AIN_STALL_MS = 1800;
	localparam int unsigned AIN_STALL_CYC = AIN_STALL_MS * (CLK_HZ / 1000);
	localparam int unsigned OVERSPEED_PCT = 5;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SAFETY = 8'h00;
	localparam logic [7:0] OFS_PORT = 8'h04;
	localparam logic [7:0] OFS_ROUTE = 8'h08;
	localparam logic [7:0] OFS_PLAY = 8'h0c;
	localparam logic [7:0] OFS_ERROR = 8'h10;
	localparam int unsigned SAFE_BCLK_BIT = 0;
	localparam int unsigned SAFE_FRAME_BIT = 1;
	localparam int unsigned SAFE_AIN_BIT = 2;
	localparam int unsigned SAFE_MIX_BIT = 3;
	localparam int unsigned PORT_OUT_BIT = 4;
	localparam int unsigned PORT_IN_BIT = 5;
	localparam int unsigned ROUTE_LEFT_EN_BIT = 0;
	localparam int unsigned ROUTE_RIGHT_EN_BIT = 1;
	localparam int unsigned ROUTE_LEFT_CH_LSB = 2;
	localparam int unsigned ROUTE_RIGHT_CH_LSB = 4;
	localparam int unsigned PLAY_CH_LSB = 4;
	localparam int unsigned ERR_HALT_BIT = 8;
	localparam logic [3:0] SAFETY_RST = 4'h0;
	localparam logic [5:0] PORT_RST = 6'h00;
	localparam logic [5:0] ROUTE_RST = 6'h00;
	localparam logic [1:0] MIX_LIMIT_CH = 2'h3;

	typedef enum logic [3:0] {
		RATE_8K = 4'h0,
		RATE_16K = 4'h1,
		RATE_32K = 4'h2,
		RATE_11K = 4'h3,
		RATE_22K = 4'h4,
		RATE_44K = 4'h5,
		RATE_12K = 4'h6,
		RATE_24K = 4'h7,
		RATE_48K = 4'h8
	} rate_type;

	typedef enum logic [2:0] {
		OP_PLAY = 3'h0,
		OP_EXT_PLAY = 3'h1,
		OP_START = 3'h2,
		OP_SILENCE = 3'h3,
		OP_STOP = 3'h4
	} play_op_type;

	typedef enum logic [1:0] {
		PB_RUN = 2'b00,
		PB_HALT = 2'b01,
		PB_REARM = 2'b10
	} pb_state_type;

	// Shortest legal frame period in clock cycles; zero disables the check.
	function automatic logic [31:0] frame_min_cycles(input logic [3:0] code);
		int unsigned hz;
		hz = 0;
		case (code)
			RATE_8K: hz = 8000;
			RATE_16K: hz = 16000;
			RATE_32K: hz = 32000;
			RATE_11K: hz = 11025;
			RATE_22K: hz = 22050;
			RATE_44K: hz = 44100;
			RATE_12K: hz = 12000;
			RATE_24K: hz = 24000;
			RATE_48K: hz = 48000;
			default: hz = 0;
		endcase
		if (hz == 0) begin
			return 32'h0;
		end
		return 32'(CLK_HZ / hz * 100 / (100 + OVERSPEED_PCT));
	endfunction

endpackage

/* File: rtl/audio_port_fault_monitor.sv */
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Bit clock stall sets its fault flag.
// RULE2 - Bit clock flag readable, cleared by clear.
// RULE3 - Frame clock stall sets its fault flag.
// RULE4 - Frame clock flag readable, cleared by clear.
// RULE5 - Fast frame clock resets routing, halts playback.
// RULE6 - Monitor off: overspeed halts, flag stays zero.
// RULE7 - Monitor on: overspeed halts and sets flag.
// RULE8 - Stay halted until host reconfigures.
// RULE9 - Host recovers: good clock, silence, routing.
// RULE10 - Data input idle 1.8 s sets flag.
// RULE11 - Audio input flag readable, cleared by clear.
// RULE12 - Output-only port ignores the data input.
// RULE13 - Mix limits checked only when enabled.
// RULE14 - High rate channel 3 playback refused, flagged.
// RULE15 - High rate routing to channel 3 refused.
// RULE16 - Mix flag readable, cleared by clear.
// RULE17 - Flags stay set until clear or reset.
// RULE18 - Stall monitors need port enabled, master clock.
module audio_port_fault_monitor #(
	parameter int unsigned FRAME_STALL_CYC = audio_fault_pkg::FRAME_STALL_CYC,
	parameter int unsigned AIN_STALL_CYC = audio_fault_pkg::AIN_STALL_CYC
) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial audio link
	input wire logic bitclk_i,
	input wire logic frameclk_i,
	input wire logic serial_audio_data_in_i,
	// Playback control
	output logic playback_halt_o,
	output logic cmd_valid_o,
	output logic [2:0] cmd_op_o,
	output logic [1:0] cmd_ch_o,
	output logic [5:0] route_o,
	output logic [3:0] fault_flags_o
);

	// ----------------------------------------------------------------
	// Link domain capture
	// ----------------------------------------------------------------
	logic [1:0] lrst_q;
	logic btog_q;
	logic fcap_q;
	logic dcap_q;

	always_ff @(posedge bitclk_i) begin
		lrst_q <= {lrst_q[0], rst_i};
	end

	// The bit clock cannot watch itself, so it only toggles a level that
	// the master clock checks for motion.
	always_ff @(posedge bitclk_i) begin
		if (lrst_q[1]) begin
			btog_q <= 1'b0;
			fcap_q <= 1'b0;
			dcap_q <= 1'b0;
		end else begin
			btog_q <= ~btog_q;
			fcap_q <= frameclk_i;
			dcap_q <= serial_audio_data_in_i;
		end
	end

	// ----------------------------------------------------------------
	// Crossing into the master clock domain
	// ----------------------------------------------------------------
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end else begin
			s1_q <= {dcap_q, fcap_q, btog_q};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	wire [2:0] chg_w = s2_q ^ s3_q;
	wire frame_rise_w = s2_q[1] & ~s3_q[1];

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic ack_q;
	logic [31:0] rdat_q;
	logic [3:0] safety_q;
	logic [5:0] port_q;
	logic [5:0] route_q;
	logic [5:0] route_d;
	logic [3:0] flag_q;
	logic [3:0] flag_d;

	wire req_w = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_w = req_w & wb_we_i & wb_sel_i[0];
	wire hit_safety_w = wb_adr_i == audio_fault_pkg::OFS_SAFETY;
	wire hit_port_w = wb_adr_i == audio_fault_pkg::OFS_PORT;
	wire hit_route_w = wb_adr_i == audio_fault_pkg::OFS_ROUTE;
	wire hit_play_w = wb_adr_i == audio_fault_pkg::OFS_PLAY;
	wire hit_err_w = wb_adr_i == audio_fault_pkg::OFS_ERROR;
	wire clr_w = wr_w & hit_err_w;

	wire en_bclk_w = safety_q[audio_fault_pkg::SAFE_BCLK_BIT];
	wire en_frame_w = safety_q[audio_fault_pkg::SAFE_FRAME_BIT];
	wire en_ain_w = safety_q[audio_fault_pkg::SAFE_AIN_BIT];
	wire en_mix_w = safety_q[audio_fault_pkg::SAFE_MIX_BIT];
	wire out_en_w = port_q[audio_fault_pkg::PORT_OUT_BIT];
	wire in_en_w = port_q[audio_fault_pkg::PORT_IN_BIT];
	wire port_on_w = out_en_w | in_en_w;

	audio_fault_pkg::pb_state_type state_q;
	audio_fault_pkg::pb_state_type state_d;

	wire [31:0] err_view_w = {23'h0, state_q != audio_fault_pkg::PB_RUN, 4'h0, flag_q};
	wire [31:0] rdat_w = hit_safety_w ? {28'h0, safety_q} :
		hit_port_w ? {26'h0, port_q} :
		hit_route_w ? {26'h0, route_q} :
		hit_err_w ? err_view_w : 32'h0; // RULE2 RULE4 RULE11 RULE16

	// Every access, mapped or not, is answered one cycle after it arrives.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= req_w;
			rdat_q <= req_w ? rdat_w : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			safety_q <= audio_fault_pkg::SAFETY_RST;
			port_q <= audio_fault_pkg::PORT_RST;
		end else begin
			if (wr_w && hit_safety_w) begin
				safety_q <= wb_dat_i[3:0];
			end
			if (wr_w && hit_port_w) begin
				port_q <= wb_dat_i[5:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Stall monitors
	// ----------------------------------------------------------------
	// Data input watch needs the input side on; an output-only port leaves it idle.
	wire [2:0] armed_w = {en_ain_w & in_en_w, en_frame_w & port_on_w,
		en_bclk_w & port_on_w}; // RULE12 RULE18
	logic [2:0] stall_w;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stall
			localparam logic [31:0] LIMIT = (gi == 0) ?
				32'(audio_fault_pkg::BCLK_STALL_CYC) :
				(gi == 1) ? 32'(FRAME_STALL_CYC) : 32'(AIN_STALL_CYC);
			logic [31:0] cnt_q;
			// Counting on the master clock keeps detection alive when the link stops.
			always_ff @(posedge clk_i) begin
				if (rst_i || !armed_w[gi] || chg_w[gi]) begin
					cnt_q <= 32'h0;
				end else if (cnt_q != LIMIT - 32'h1) begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
			assign stall_w[gi] = armed_w[gi] & ~chg_w[gi] & (cnt_q == LIMIT - 32'h1); // RULE18
		end
	endgenerate

	// ----------------------------------------------------------------
	// Frame overspeed
	// ----------------------------------------------------------------
	logic [31:0] per_q;
	logic seen_q;
	wire [31:0] min_per_w = audio_fault_pkg::frame_min_cycles(port_q[3:0]);
	// A period below the minimum means the frame clock runs over 5 % fast.
	wire ovs_w = frame_rise_w & seen_q & port_on_w & (per_q < min_per_w); // RULE5

	always_ff @(posedge clk_i) begin
		if (rst_i || !port_on_w) begin
			per_q <= 32'h0;
			seen_q <= 1'b0;
		end else if (frame_rise_w) begin
			per_q <= 32'h1;
			seen_q <= 1'b1;
		end else if (per_q != 32'hffffffff) begin
			per_q <= per_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Mix limit and commands
	// ----------------------------------------------------------------
	wire rate_hi_w = (port_q[3:0] >= audio_fault_pkg::RATE_11K) &&
		(port_q[3:0] <= audio_fault_pkg::RATE_48K);
	wire lanes_on_w = route_q[audio_fault_pkg::ROUTE_LEFT_EN_BIT] |
		route_q[audio_fault_pkg::ROUTE_RIGHT_EN_BIT];
	wire [2:0] op_w = wb_dat_i[2:0];
	wire [1:0] ch_w = wb_dat_i[audio_fault_pkg::PLAY_CH_LSB +: 2];
	wire op_starts_w = (op_w == audio_fault_pkg::OP_PLAY) ||
		(op_w == audio_fault_pkg::OP_EXT_PLAY) ||
		(op_w == audio_fault_pkg::OP_START) || (op_w == audio_fault_pkg::OP_SILENCE);
	wire play_wr_w = wr_w & hit_play_w;
	wire mix_play_w = en_mix_w & rate_hi_w & lanes_on_w & op_starts_w &
		(ch_w == audio_fault_pkg::MIX_LIMIT_CH); // RULE13 RULE14
	wire new_lanes_w = wb_dat_i[audio_fault_pkg::ROUTE_LEFT_EN_BIT] |
		wb_dat_i[audio_fault_pkg::ROUTE_RIGHT_EN_BIT];
	wire new_ch3_w =
		(wb_dat_i[audio_fault_pkg::ROUTE_LEFT_CH_LSB +: 2] == audio_fault_pkg::MIX_LIMIT_CH) ||
		(wb_dat_i[audio_fault_pkg::ROUTE_RIGHT_CH_LSB +: 2] == audio_fault_pkg::MIX_LIMIT_CH);
	wire route_wr_w = wr_w & hit_route_w;
	wire mix_route_w = en_mix_w & rate_hi_w & new_lanes_w & new_ch3_w; // RULE13 RULE15
	wire route_acc_w = route_wr_w & ~mix_route_w; // RULE15
	wire play_acc_w = play_wr_w & ~mix_play_w; // RULE14
	wire silence_acc_w = play_acc_w & (op_w == audio_fault_pkg::OP_SILENCE);

	logic cmd_valid_q;
	logic [2:0] cmd_op_q;
	logic [1:0] cmd_ch_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_valid_q <= 1'b0;
			cmd_op_q <= 3'h0;
			cmd_ch_q <= 2'h0;
		end else begin
			cmd_valid_q <= play_acc_w;
			if (play_acc_w) begin
				cmd_op_q <= op_w;
				cmd_ch_q <= ch_w;
			end
		end
	end

	always_comb begin
		route_d = route_q;
		if (ovs_w) begin
			route_d = audio_fault_pkg::ROUTE_RST; // RULE5
		end else if (route_acc_w) begin
			route_d = wb_dat_i[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Playback halt sequence
	// ----------------------------------------------------------------
	// A good frame clock alone does not resume; the host must send silence, then routing.
	always_comb begin
		state_d = state_q;
		case (state_q)
			audio_fault_pkg::PB_RUN: begin
				if (ovs_w) begin
					state_d = audio_fault_pkg::PB_HALT;
				end
			end
			audio_fault_pkg::PB_HALT: begin
				if (silence_acc_w && !ovs_w) begin
					state_d = audio_fault_pkg::PB_REARM; // RULE8 RULE9
				end
			end
			audio_fault_pkg::PB_REARM: begin
				if (ovs_w) begin
					state_d = audio_fault_pkg::PB_HALT;
				end else if (route_acc_w) begin
					state_d = audio_fault_pkg::PB_RUN; // RULE8 RULE9
				end
			end
			default: state_d = audio_fault_pkg::PB_HALT;
		endcase
	end

	logic halt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= audio_fault_pkg::PB_RUN;
			halt_q <= 1'b0;
			route_q <= audio_fault_pkg::ROUTE_RST;
		end else begin
			state_q <= state_d;
			halt_q <= state_d != audio_fault_pkg::PB_RUN; // RULE5 RULE8
			route_q <= route_d;
		end
	end

	// ----------------------------------------------------------------
	// Fault flags
	// ----------------------------------------------------------------
	// An event in the clearing cycle survives the clear.
	wire [3:0] set_w = {mix_play_w | mix_route_w, stall_w[2],
		stall_w[1] | (ovs_w & en_frame_w), stall_w[0]}; // RULE1 RULE3 RULE6 RULE7 RULE10

	always_comb begin
		flag_d = (flag_q & ~{4{clr_w}}) | set_w; // RULE17 RULE2 RULE4 RULE11 RULE16
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 4'h0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign playback_halt_o = halt_q;
	assign cmd_valid_o = cmd_valid_q;
	assign cmd_op_o = cmd_op_q;
	assign cmd_ch_o = cmd_ch_q;
	assign route_o = route_q;
	assign fault_flags_o = flag_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_bclk_stall_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		stall_w[0] |=> flag_q[0] && fault_flags_o[0])
		else $error("bit clock stall did not raise its flag");
	a_error_clear_all: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		clr_w && set_w == 4'h0 |=> flag_q == 4'h0 ##1 (!wb_ack_o || wb_dat_o[3:0] == 4'h0))
		else $error("clear left a fault flag set");
	a_frame_stall_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		stall_w[1] |=> flag_q[1])
		else $error("frame clock stall did not raise its flag");
	a_ovs_halts: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
		ovs_w |=> playback_halt_o && route_o == 6'h00)
		else $error("overspeed did not halt and reset routing");
	a_ovs_no_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		ovs_w && !en_frame_w && !stall_w[1] && !flag_q[1] |=> !flag_q[1])
		else $error("overspeed set frame flag while monitor off");
	a_ovs_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
		ovs_w && en_frame_w |=> flag_q[1] && halt_q)
		else $error("overspeed with monitor on did not flag");
	a_halt_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		halt_q && !route_acc_w |=> halt_q)
		else $error("halt released without a routing command");
	a_ain_stall_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
		stall_w[2] |=> flag_q[2] && $past(g_stall[2].cnt_q) == AIN_STALL_CYC - 1)
		else $error("audio input idle did not raise its flag");
	a_ain_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
		!in_en_w |-> !stall_w[2] ##1 g_stall[2].cnt_q == 32'h0)
		else $error("data input watched while input disabled");
	a_mix_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
		!en_mix_w |-> !mix_play_w && !mix_route_w)
		else $error("mix check active while disabled");
	a_mix_play_drop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
		play_wr_w && mix_play_w |=> !cmd_valid_o && flag_q[3])
		else $error("channel 3 command passed at high rate");
	a_mix_route_drop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
		route_wr_w && mix_route_w && !ovs_w |=> $stable(route_o) && flag_q[3])
		else $error("channel 3 routing accepted at high rate");
	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
		(flag_q != 4'h0) && !clr_w |=> (flag_q & $past(flag_q)) == $past(flag_q))
		else $error("fault flag dropped without a clear");

endmodule // audio_port_fault_monitor

/* File: test/audio_link_master.sv */
`timescale 1ns/1ns
// Far-side serial audio master. Its clocks stop only when a stall is commanded.
module audio_link_master (
	// Control from the bench
	input wire logic run_i,
	input wire logic frame_run_i,
	input wire logic data_run_i,
	input wire logic [9:0] half_i,
	// Link
	output logic bitclk_o,
	output logic frameclk_o,
	output logic data_o
);
	int cnt;
	initial begin
		bitclk_o = 1'b0;
		frameclk_o = 1'b0;
		data_o = 1'b0;
		cnt = 0;
		#7;
		forever begin
			#24;
			if (run_i) begin
				bitclk_o = ~bitclk_o;
			end
		end
	end
	// Frame and data move on the falling edge, so the rising edge samples settled levels.
	always @(negedge bitclk_o) begin
		cnt = cnt + 1;
		if (cnt >= half_i) begin
			cnt = 0;
			if (frame_run_i) begin
				frameclk_o = ~frameclk_o;
			end
		end
		if (data_run_i) begin
			data_o = ~data_o;
		end
	end
endmodule // audio_link_master

/* File: test/audio_port_fault_monitor_tb.sv */
`timescale 1ns/1ns
module audio_port_fault_monitor_tb;
	// Stall counts are shortened; both stay above one half frame at 48 kHz.
	localparam int FS = 3000;
	localparam int AS = 4000;
	localparam int LIMIT = 90000;
	logic clk_i;
	logic rst_i;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic bitclk;
	logic frameclk;
	logic sdata;
	logic playback_halt_o;
	logic cmd_valid_o;
	logic [2:0] cmd_op_o;
	logic [1:0] cmd_ch_o;
	logic [5:0] route_o;
	logic [3:0] fault_flags_o;
	logic run;
	logic frun;
	logic drun;
	logic [9:0] half;
	logic [31:0] rdat;
	logic [5:0] cv;
	logic [3:0] m_safe;
	logic [3:0] m_flags;
	logic [5:0] m_port;
	logic [5:0] m_route;
	logic m_halt;
	logic m_sil;
	logic m_valid;
	logic [2:0] m_op;
	logic [1:0] m_ch;
	logic [1:0] ch;
	int seed = 9640;
	int cycles = 0;
	int num_errors = 0;
	int compares = 0;

	audio_port_fault_monitor #(.FRAME_STALL_CYC(FS), .AIN_STALL_CYC(AS)) audio_port_fault_monitor_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .bitclk_i(bitclk), .frameclk_i(frameclk),
		.serial_audio_data_in_i(sdata), .playback_halt_o(playback_halt_o),
		.cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o), .cmd_ch_o(cmd_ch_o),
		.route_o(route_o), .fault_flags_o(fault_flags_o));
	audio_link_master audio_link_master_i (.run_i(run), .frame_run_i(frun), .data_run_i(drun),
		.half_i(half), .bitclk_o(bitclk), .frameclk_o(frameclk), .data_o(sdata));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors = num_errors + 1;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus tasks and reference model
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("compares=%0d errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Waits as long as the answer takes; only the cycle ceiling ends a hang.
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cv = {cmd_valid_o, cmd_op_o, cmd_ch_o};
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp(rdat, e);
	endtask

	// Writes a register and advances the model as the device should.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic hit;
		hit = m_safe[3] && m_port[3:0] >= 4'h3 && m_port[3:0] <= 4'h8;
		wb(1'b1, a, d);
		m_valid = 1'b0;
		case (a)
			audio_fault_pkg::OFS_SAFETY: m_safe = d[3:0];
			audio_fault_pkg::OFS_PORT: m_port = d[5:0];
			audio_fault_pkg::OFS_ERROR: m_flags = 4'h0;
			audio_fault_pkg::OFS_ROUTE: begin
				if (hit && d[1:0] != 2'h0 && (d[3:2] == 2'h3 || d[5:4] == 2'h3)) begin
					m_flags[3] = 1'b1;
				end else begin
					m_halt = m_halt && !m_sil;
					m_route = d[5:0];
				end
			end
			audio_fault_pkg::OFS_PLAY: begin
				if (hit && m_route[1:0] != 2'h0 && d[2:0] <= 3'h3 && d[5:4] == 2'h3) begin
					m_flags[3] = 1'b1;
				end else begin
					m_valid = 1'b1;
					m_op = d[2:0];
					m_ch = d[5:4];
					m_sil = m_sil || (m_halt && d[2:0] == 3'h3);
				end
				cmp({26'h0, cv}, {26'h0, m_valid, m_op, m_ch});
			end
			default: ;
		endcase
	endtask

	task automatic ovs;
		m_halt = 1'b1;
		m_route = 6'h0;
		m_sil = 1'b0;
		m_flags[1] = m_flags[1] | m_safe[1];
	endtask

	task automatic check_all;
		rd(audio_fault_pkg::OFS_ERROR, {23'h0, m_halt, 4'h0, m_flags});
		rd(audio_fault_pkg::OFS_ROUTE, {26'h0, m_route});
		#1;
		cmp({28'h0, fault_flags_o}, {28'h0, m_flags});
		cmp({31'h0, playback_halt_o}, {31'h0, m_halt});
		cmp({26'h0, route_o}, {26'h0, m_route});
	endtask

	task automatic play(input logic [2:0] op, input logic [1:0] c);
		wr(audio_fault_pkg::OFS_PLAY, {26'h0, c, 1'b0, op});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{rst_i, cyc, stb, we, adr, wdat, m_safe, m_flags, m_port} = '0;
		{m_route, m_halt, m_sil, m_valid, m_op, m_ch} = '0;
		rst_i = 1'b1;
		sel = 4'hf;
		{run, frun, drun} = 3'b111;
		half = 10'd217;
		// Five cycles cover one bit clock edge, which the two-stage link copy of reset stretches.
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check_all();
		rd(8'h40, 32'h0);
		$display("test reset done");

		wr(audio_fault_pkg::OFS_PORT, 32'h18);
		wr(audio_fault_pkg::OFS_SAFETY, 32'h1);
		repeat (200) @(posedge clk_i);
		run <= 1'b0;
		repeat (900) @(posedge clk_i);
		check_all();
		repeat (300) @(posedge clk_i);
		m_flags[0] = 1'b1;
		check_all();
		run <= 1'b1;
		repeat (300) @(posedge clk_i);
		check_all();
		wr(audio_fault_pkg::OFS_ERROR, 32'h1);
		check_all();
		$display("test bitclk done");

		wr(audio_fault_pkg::OFS_SAFETY, 32'h2);
		frun <= 1'b0;
		repeat (FS + 500) @(posedge clk_i);
		m_flags[1] = 1'b1;
		check_all();
		frun <= 1'b1;
		repeat (3000) @(posedge clk_i);
		check_all();
		wr(audio_fault_pkg::OFS_ERROR, 32'h1);
		check_all();
		$display("test frame stall done");

		wr(audio_fault_pkg::OFS_PORT, 32'h38);
		wr(audio_fault_pkg::OFS_SAFETY, 32'h4);
		drun <= 1'b0;
		repeat (AS + 500) @(posedge clk_i);
		m_flags[2] = 1'b1;
		check_all();
		drun <= 1'b1;
		repeat (100) @(posedge clk_i);
		check_all();
		wr(audio_fault_pkg::OFS_ERROR, 32'h1);
		check_all();
		wr(audio_fault_pkg::OFS_PORT, 32'h18);
		drun <= 1'b0;
		repeat (AS + 500) @(posedge clk_i);
		check_all();
		drun <= 1'b1;
		wr(audio_fault_pkg::OFS_SAFETY, 32'h0);
		$display("test audio input done");

		for (int mon = 0; mon < 2; mon++) begin
			wr(audio_fault_pkg::OFS_SAFETY, {30'h0, mon[0], 1'b0});
			ch = 2'($unsigned($random(seed)) % 3);
			wr(audio_fault_pkg::OFS_ROUTE, {26'h0, ch, 2'h1, 2'h3});
			half <= 10'd150;
			repeat (6000) @(posedge clk_i);
			ovs();
			check_all();
			half <= 10'd217;
			repeat (6000) @(posedge clk_i);
			check_all();
			play(3'h3, ch);
			check_all();
			wr(audio_fault_pkg::OFS_ROUTE, {26'h0, 2'h2, ch, 2'h3});
			check_all();
			wr(audio_fault_pkg::OFS_ERROR, 32'h1);
		end
		$display("test overspeed done");

		wr(audio_fault_pkg::OFS_PORT, 32'h3 + 32'($unsigned($random(seed)) % 6));
		wr(audio_fault_pkg::OFS_SAFETY, 32'h8);
		wr(audio_fault_pkg::OFS_ROUTE, 32'h1);
		for (int op = 0; op < 5; op++) begin
			play(op[2:0], 2'h3);
		end
		ch = 2'($unsigned($random(seed)) % 3);
		play(3'h0, ch);
		wr(audio_fault_pkg::OFS_ROUTE, 32'h0d);
		check_all();
		wr(audio_fault_pkg::OFS_ERROR, 32'h1);
		check_all();
		wr(audio_fault_pkg::OFS_SAFETY, 32'h0);
		play(3'h1, 2'h3);
		wr(audio_fault_pkg::OFS_ROUTE, 32'h31);
		wr(audio_fault_pkg::OFS_SAFETY, 32'h8);
		wr(audio_fault_pkg::OFS_PORT, 32'h00);
		play(3'h2, 2'h3);
		check_all();
		$display("test mix done");
		stop_test();
	end
endmodule // audio_port_fault_monitor_tb
